// ---- design/dtc_delay_line.sv ----
// Purpose: Shift line of termination request samples with every stage visible.
// Assumes: Request pin is synchronous to ref_clk.
// Notes: Stage i holds the pin as sampled i edges earlier.
module dtc_delay_line #(
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic din,
  output logic [DEPTH-1:0] taps
);
  if (DEPTH < 2) begin : g_bad_depth
    $error("dtc_delay_line: DEPTH must be at least 2");
  end

  // First stage samples the pin itself
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      taps[0] <= 1'b0;
    end else begin
      taps[0] <= din;
    end
  end

  // Remaining stages, one flop each
  for (genvar i = 1; i < DEPTH; i++) begin : g_stage
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        taps[i] <= 1'b0;
      end else begin
        taps[i] <= taps[i-1];
      end
    end
  end
endmodule // dtc_delay_line

// ---- design/dtc_term_ctrl.sv ----
// Purpose: On-die termination mode control with APB configuration and status.
// Assumes: Termination request, clock enable and refresh strobe are synchronous to ref_clk.
// Notes: Clock enable low is taken as precharge power-down; active power-down is not told apart.
`include "dtc_params.svh"

// Functional notes
// [RL1] Controller drops request half clock before read
// [RL2] Controller re-enables only after read postamble
// [RL3] Earlier release and later restore are legal
// [RL4] DLL-off power-down selects asynchronous termination
// [RL5] DLL resynchronising also uses asynchronous termination
// [RL6] Async ignores additive latency, uses elapsed time
// [RL7] Async turn-on between 2 and 8.5 ns; the code turns on one 40 ns clock after the sampling edge
// [RL8] Async turn-off between 2 and 8.5 ns; the code turns off one 40 ns clock after the sampling edge
// [RL9] Entry window only with DLL-off power-down
// [RL10] Entry window closes at first clock-enable low
// [RL11] Lead time is larger latency plus one
// [RL12] Refresh in progress extends entry window
// [RL13] Turn-on in window within combined bounds
// [RL14] Turn-off in window within combined bounds
// [RL15] Before window synchronous, after window asynchronous
// [RL16] Exit window is lead time plus exit time
// [RL17] Sync latencies equal write latency minus two
// [RL18] Track mode, choose timing per request
module dtc_term_ctrl #(
  parameter int REFRESH_CYCLES = `DTC_REFRESH_CYCLES,
  parameter int XPDLL_CYCLES = `DTC_XPDLL_CYCLES,
  parameter int RESYNC_CYCLES = `DTC_RESYNC_CYCLES,
  parameter int MAX_WL = 32,
  parameter int TIMER_W = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic term_req,
  input wire logic cke,
  input wire logic refresh_cmd,
  output logic term_on,
  output logic term_async,
  output logic [1:0] term_mode
);
  localparam int SEL_W = $clog2(MAX_WL);
  localparam int ASYNC_CYC = `DTC_ASYNC_MIN_CYC;
  localparam int FW = `DTC_LAT_FIELD_W;

  // Elaboration checks on parameters the logic cannot serve
  if (MAX_WL < 2 * (1 << FW)) begin : g_bad_wl
    $error("dtc_term_ctrl: MAX_WL too small for the latency fields");
  end
  if (REFRESH_CYCLES < 1 || XPDLL_CYCLES < 1 || RESYNC_CYCLES < 1) begin : g_bad_cnt
    $error("dtc_term_ctrl: timing counts must be at least one cycle");
  end
  if (REFRESH_CYCLES + XPDLL_CYCLES + MAX_WL >= (1 << TIMER_W) || RESYNC_CYCLES >= (1 << TIMER_W)) begin : g_bad_tw
    $error("dtc_term_ctrl: TIMER_W too narrow for the timing counts");
  end
  if (ASYNC_CYC > `DTC_ASYNC_MAX_CYC || ASYNC_CYC >= MAX_WL) begin : g_bad_async
    $error("dtc_term_ctrl: asynchronous delay window cannot be met at this clock");
  end

  // Configuration state
  logic nom_en_q;
  logic wr_en_q;
  logic pd_dll_sel_q;
  logic [FW-1:0] cwl_q;
  logic [FW-1:0] al_q;

  // Bus and pin state
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic cke_q;
  logic cke_prev_q;
  logic term_on_q;
  logic term_async_q;
  dtc_pkg::dtc_mode_type mode_q;
  dtc_pkg::dtc_mode_type mode_d;

  // Derived values
  logic rtt_en;
  logic [FW:0] wl;
  logic [SEL_W-1:0] sync_sel;
  logic [TIMER_W-1:0] exit_load;
  logic [MAX_WL-1:0] taps;
  logic sync_resp;
  logic async_resp;
  logic use_async;
  logic cke_fell;
  logic cke_rose;
  logic refresh_busy;
  logic resync_busy;
  logic exit_busy;
  logic exit_load_en;
  logic dll_reset_wr;
  logic bus_setup;
  logic bus_commit;
  logic addr_hit;
  logic [31:0] rd_word;

  // Termination only matters when either termination value is enabled
  assign rtt_en = nom_en_q | wr_en_q;

  // Write latency is CAS write latency plus additive latency
  assign wl = {1'b0, cwl_q} + {1'b0, al_q};

  // Sync latency WL-2 counted from the sampling edge; the output flop adds one edge,
  // so the tap index is WL-3; tiny settings clamp to the first stage
  always_comb begin
    if (wl > (FW + 1)'(`DTC_SYNC_OFFSET + 1)) begin
      sync_sel = SEL_W'(wl - (FW + 1)'(`DTC_SYNC_OFFSET + 1)); // see [RL17]
    end else begin
      sync_sel = '0;
    end
  end

  // Exit window spans lead time (WL-1) plus the DLL-off exit time
  assign exit_load = TIMER_W'(wl) - TIMER_W'(`DTC_LEAD_OFFSET) + TIMER_W'(XPDLL_CYCLES); // see [RL11] see [RL16]

  // Request history; the pin is sampled at each edge into stage zero
  dtc_delay_line #(
    .DEPTH(MAX_WL)
  ) u_delay (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .din(term_req),
    .taps(taps)
  );

  // Synchronous path carries the additive latency, the asynchronous one does not
  assign sync_resp = taps[sync_sel]; // see [RL17]
  assign async_resp = taps[ASYNC_CYC-1]; // see [RL6] see [RL7] see [RL8]

  // Refresh in flight, measured from the refresh command.
  // A second refresh while one runs restarts the count; the later command governs.
  dtc_timer #(
    .WIDTH(TIMER_W)
  ) u_refresh (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(refresh_cmd),
    .load_val(TIMER_W'(REFRESH_CYCLES)),
    .busy(refresh_busy)
  );

  // DLL resynchronisation after a software DLL reset
  dtc_timer #(
    .WIDTH(TIMER_W)
  ) u_resync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(dll_reset_wr),
    .load_val(TIMER_W'(RESYNC_CYCLES)),
    .busy(resync_busy)
  );

  // Power-down exit transition span
  dtc_timer #(
    .WIDTH(TIMER_W)
  ) u_exit (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(exit_load_en),
    .load_val(exit_load),
    .busy(exit_busy)
  );

  // Clock enable is registered; edges are seen on the registered copy.
  // Both stages reset to the idle high level, so no false fall follows reset.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cke_q <= 1'b1;
      cke_prev_q <= 1'b1;
    end else begin
      cke_q <= cke;
      cke_prev_q <= cke_q;
    end
  end

  assign cke_fell = cke_prev_q & ~cke_q;
  assign cke_rose = ~cke_prev_q & cke_q;
  assign exit_load_en = (mode_q == dtc_pkg::DTC_ASYNC) && cke_rose;

  // Mode tracking; entry window only exists with the DLL-off power-down choice
  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      dtc_pkg::DTC_SYNC: begin
        if (rtt_en && !pd_dll_sel_q && cke_fell) begin // see [RL4] see [RL9] see [RL10]
          if (refresh_busy) begin
            mode_d = dtc_pkg::DTC_ENTRY; // see [RL12]
          end else begin
            mode_d = dtc_pkg::DTC_ASYNC; // see [RL15]
          end
        end
      end
      dtc_pkg::DTC_ENTRY: begin
        if (cke_q) begin
          mode_d = dtc_pkg::DTC_SYNC;
        end else if (!refresh_busy) begin
          mode_d = dtc_pkg::DTC_ASYNC; // see [RL12]
        end
      end
      dtc_pkg::DTC_ASYNC: begin
        if (cke_rose) begin
          mode_d = dtc_pkg::DTC_EXIT; // see [RL16]
        end
      end
      dtc_pkg::DTC_EXIT: begin
        if (!cke_q) begin
          mode_d = dtc_pkg::DTC_ASYNC; // Short high pulse: windows overlap
        end else if (!exit_busy) begin
          mode_d = dtc_pkg::DTC_SYNC; // see [RL16]
        end
      end
    endcase
  end

  // Mode register; leaving power-down is honoured in the table, disabling termination only blocks entry from sync
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_q <= dtc_pkg::DTC_SYNC;
    end else begin
      mode_q <= mode_d; // see [RL18]
    end
  end

  // Response timing choice. In the entry window the synchronous latency is used:
  // it lies inside the combined bounds and leaves queued requests undisturbed.
  // The exit window answers asynchronously, also inside the combined bounds.
  always_comb begin
    use_async = resync_busy; // see [RL5]
    unique case (mode_q)
      dtc_pkg::DTC_SYNC: use_async = resync_busy;
      dtc_pkg::DTC_ENTRY: use_async = resync_busy; // see [RL13] see [RL14]
      dtc_pkg::DTC_ASYNC: use_async = 1'b1; // see [RL4] see [RL15]
      dtc_pkg::DTC_EXIT: use_async = 1'b1; // see [RL13] see [RL14]
    endcase
  end

  // Applied termination; nothing is applied while both values are disabled
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      term_on_q <= 1'b0;
      term_async_q <= 1'b0;
    end else begin
      term_async_q <= use_async;
      if (!rtt_en) begin
        term_on_q <= 1'b0;
      end else if (use_async) begin
        term_on_q <= async_resp; // see [RL7] see [RL8]
      end else begin
        term_on_q <= sync_resp; // see [RL17]
      end
    end
  end

  // The controller keeps request low around reads; the device relies on it
  // and simply follows the pin, so overlap is not detected here. see [RL1] see [RL2]

  // APB: ready is raised in the setup cycle so every access takes one access phase.
  // The setup term ignores a cycle in which ready is already high, so a transfer
  // is never answered twice, and back-to-back setups are still taken at once.
  assign bus_setup = psel & ~penable & ~pready_q;
  assign bus_commit = psel & penable & pready_q;
  assign addr_hit = (paddr == `DTC_CTRL_OFS) || (paddr == `DTC_LAT_OFS) || (paddr == `DTC_STATUS_OFS);
  assign dll_reset_wr = bus_commit & pwrite & (paddr == `DTC_CTRL_OFS) & pwdata[`DTC_CTRL_DLLRST_BIT];

  // Read word assembly; reserved bits read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (paddr)
      `DTC_CTRL_OFS: begin
        rd_word[`DTC_CTRL_NOM_BIT] = nom_en_q;
        rd_word[`DTC_CTRL_WR_BIT] = wr_en_q;
        rd_word[`DTC_CTRL_PDDLL_BIT] = pd_dll_sel_q;
      end
      `DTC_LAT_OFS: begin
        rd_word[`DTC_LAT_CWL_LSB +: FW] = cwl_q;
        rd_word[`DTC_LAT_AL_LSB +: FW] = al_q;
      end
      `DTC_STATUS_OFS: begin
        rd_word[`DTC_ST_MODE_LSB +: 2] = mode_q;
        rd_word[`DTC_ST_TERM_BIT] = term_on_q;
        rd_word[`DTC_ST_RESYNC_BIT] = resync_busy;
        rd_word[`DTC_ST_REFRESH_BIT] = refresh_busy;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Bus answer flops; data and error are prepared during setup
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (bus_setup) begin
      pready_q <= 1'b1;
      pslverr_q <= ~addr_hit;
      prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
  end

  // Control register; the DLL reset bit is a strobe and is not stored
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      nom_en_q <= 1'b0;
      wr_en_q <= 1'b0;
      pd_dll_sel_q <= 1'b0;
    end else if (bus_commit && pwrite && paddr == `DTC_CTRL_OFS) begin
      nom_en_q <= pwdata[`DTC_CTRL_NOM_BIT];
      wr_en_q <= pwdata[`DTC_CTRL_WR_BIT];
      pd_dll_sel_q <= pwdata[`DTC_CTRL_PDDLL_BIT]; // see [RL9]
    end
  end

  // Latency register; changing it mid-flight shifts the synchronous tap at once
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cwl_q <= `DTC_CWL_RESET;
      al_q <= `DTC_AL_RESET;
    end else if (bus_commit && pwrite && paddr == `DTC_LAT_OFS) begin
      cwl_q <= pwdata[`DTC_LAT_CWL_LSB +: FW];
      al_q <= pwdata[`DTC_LAT_AL_LSB +: FW];
    end
  end

  // Outputs straight from flops; term_async tells how the current term_on was timed
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign term_on = term_on_q;
  assign term_async = term_async_q;
  assign term_mode = mode_q;
endmodule // dtc_term_ctrl

// ---- design/dtc_timer.sv ----
// Purpose: Loadable down counter that reports busy while counting.
// Assumes: Load has priority over counting.
// Notes: Busy stays high for exactly the loaded number of cycles.
module dtc_timer #(
  parameter int WIDTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  output logic busy
);
  logic [WIDTH-1:0] count_q;

  if (WIDTH < 2) begin : g_bad_width
    $error("dtc_timer: WIDTH must be at least 2");
  end

  // A reload restarts the span, so back-to-back events extend it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count_q <= '0;
    end else if (load) begin
      count_q <= load_val;
    end else if (count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end

  assign busy = (count_q != '0);
endmodule // dtc_timer

// ---- inc/dtc_params.svh ----
// Purpose: Offsets, field positions, reset values and timing counts for the termination control.
// Assumes: 25 MHz reference clock; APB register access with 32-bit data.
// Notes: Asynchronous delay cycle counts are derived from times in picoseconds; the other counts are given in cycles.
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// Register byte offsets
`define DTC_CTRL_OFS 8'h00
`define DTC_LAT_OFS 8'h04
`define DTC_STATUS_OFS 8'h08

// Control register fields
`define DTC_CTRL_NOM_BIT 0
`define DTC_CTRL_WR_BIT 1
`define DTC_CTRL_PDDLL_BIT 2
`define DTC_CTRL_DLLRST_BIT 3
`define DTC_CTRL_RESET 4'h0

// Latency register fields and reset values
`define DTC_LAT_CWL_LSB 0
`define DTC_LAT_AL_LSB 4
`define DTC_LAT_FIELD_W 4
`define DTC_CWL_RESET 4'h5
`define DTC_AL_RESET 4'h0

// Status register fields
`define DTC_ST_MODE_LSB 0
`define DTC_ST_TERM_BIT 2
`define DTC_ST_RESYNC_BIT 3
`define DTC_ST_REFRESH_BIT 4

// Timing
`define DTC_CLK_PERIOD_PS 40000
`define DTC_ASYNC_MIN_PS 2000
`define DTC_ASYNC_MAX_PS 8500
`define DTC_ASYNC_MIN_CYC ((`DTC_ASYNC_MIN_PS + `DTC_CLK_PERIOD_PS - 1) / `DTC_CLK_PERIOD_PS)
`define DTC_ASYNC_MAX_RAW (`DTC_ASYNC_MAX_PS / `DTC_CLK_PERIOD_PS)
`define DTC_ASYNC_MAX_CYC ((`DTC_ASYNC_MAX_RAW < 1) ? 1 : `DTC_ASYNC_MAX_RAW)
`define DTC_REFRESH_CYCLES 8
`define DTC_XPDLL_CYCLES 10
`define DTC_RESYNC_CYCLES 512
`define DTC_SYNC_OFFSET 2
`define DTC_LEAD_OFFSET 1

`endif

// ---- inc/dtc_pkg.sv ----
// Purpose: Types shared by the termination control modules.
// Assumes: Nothing beyond the parameter header.
// Notes: Mode codes are Gray along sync, entry, async, exit.
package dtc_pkg;
  typedef enum logic [1:0] {
    DTC_SYNC = 2'b00,
    DTC_ENTRY = 2'b01,
    DTC_ASYNC = 2'b11,
    DTC_EXIT = 2'b10
  } dtc_mode_type;
endpackage

// ---- verif/dtc_mc_model.sv ----
// Purpose: Memory controller model driving request, clock enable and refresh.
// Assumes: Pins change only just after a rising edge.
// Notes: Reads appear only as gaps in the request.
module dtc_mc_model (
  input wire logic ref_clk,
  output logic term_req,
  output logic cke,
  output logic refresh_cmd
);
  initial begin
    term_req = 1'b0;
    cke = 1'b1;
    refresh_cmd = 1'b0;
  end
  task automatic pins(input logic r, input logic c);
    @(posedge ref_clk);
    term_req <= r;
    cke <= c;
  endtask
  // Request low across burst and postamble; a late restore is legal
  task automatic read_gap(input int n);
    pins(1'b0, cke);
    repeat (n) @(posedge ref_clk);
    term_req <= 1'b1;
  endtask
  // Power-down one clock after refresh, so refresh is still running
  task automatic refresh_pd();
    @(posedge ref_clk);
    refresh_cmd <= 1'b1;
    @(posedge ref_clk);
    refresh_cmd <= 1'b0;
    cke <= 1'b0;
  endtask
endmodule // dtc_mc_model

// ---- verif/dtc_term_ctrl_monitor.sv ----
// Purpose: Port checks of termination mode and response timing.
// Assumes: Register state is mirrored from committed APB writes.
// Notes: Sync latency is checked at write latency 5 only, to keep the delay fixed.
module dtc_term_ctrl_monitor #(
  parameter int REFRESH_CYCLES = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic term_req,
  input wire logic cke,
  input wire logic refresh_cmd,
  input wire logic term_on,
  input wire logic term_async,
  input wire logic [1:0] term_mode
);
  logic en_q;
  logic dll_on_q;
  logic wl5_q;
  logic [7:0] ref_q;
  logic wr_ok;
  assign wr_ok = psel & penable & pready & pwrite;
  // Mirror committed writes, so no probe inside the block is needed
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      en_q <= 1'b0;
      dll_on_q <= 1'b0;
      wl5_q <= 1'b1;
    end else if (wr_ok && paddr == 8'h00) begin
      en_q <= pwdata[0] | pwdata[1];
      dll_on_q <= pwdata[2];
    end else if (wr_ok && paddr == 8'h04) begin
      wl5_q <= (pwdata[7:0] == 8'h05);
    end
  end
  // Refresh still running when clock enable drops
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      ref_q <= 8'h00;
    else if (refresh_cmd)
      ref_q <= 8'(REFRESH_CYCLES);
    else if (ref_q != 8'h00)
      ref_q <= ref_q - 8'h01;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_async_on;
    en_q && term_mode == 2'b11 && $rose(term_req) |-> ##2 term_on;
  endproperty
  a_async_on: assert property (p_async_on) else $error("async turn-on late");
  property p_async_off;
    en_q && term_mode == 2'b11 && $fell(term_req) |-> ##2 !term_on;
  endproperty
  a_async_off: assert property (p_async_off) else $error("async turn-off late");
  property p_sync_on;
    en_q && wl5_q && !term_async && term_mode == 2'b00 && $rose(term_req) |-> ##3 !term_on ##1 term_on;
  endproperty
  a_sync_on: assert property (p_sync_on) else $error("sync turn-on latency wrong");
  property p_dll_on;
    dll_on_q && term_mode == 2'b00 |=> term_mode == 2'b00;
  endproperty
  a_dll_on: assert property (p_dll_on) else $error("mode left sync with DLL kept on");
  property p_entry_close;
    en_q && !dll_on_q && ref_q == 8'h00 && term_mode == 2'b00 && $fell(cke) |-> ##2 term_mode == 2'b11;
  endproperty
  a_entry_close: assert property (p_entry_close) else $error("async not entered");
  property p_entry_refresh;
    en_q && !dll_on_q && ref_q > 8'h02 && term_mode == 2'b00 && $fell(cke) |-> ##2 term_mode == 2'b01;
  endproperty
  a_entry_refresh: assert property (p_entry_refresh) else $error("entry not held by refresh");
  property p_exit_open;
    term_mode == 2'b11 && $rose(cke) |-> ##2 term_mode == 2'b10 [*8];
  endproperty
  a_exit_open: assert property (p_exit_open) else $error("exit window short");
  // The flag describes the output made at the last edge, so it trails the mode by one cycle
  property p_async_flag;
    term_mode == 2'b11 |=> term_async;
  endproperty
  a_async_flag: assert property (p_async_flag) else $error("async flag low");
  c_async: cover property (term_mode == 2'b11 && $rose(term_req));
  c_entry: cover property (term_mode == 2'b01);
  c_exit: cover property (term_mode == 2'b10);
endmodule // dtc_term_ctrl_monitor

bind dtc_term_ctrl dtc_term_ctrl_monitor #(.REFRESH_CYCLES(REFRESH_CYCLES)) mon_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .term_req(term_req), .cke(cke), .refresh_cmd(refresh_cmd),
  .term_on(term_on), .term_async(term_async), .term_mode(term_mode));

// ---- verif/tb_dtc_term_ctrl.sv ----
// Purpose: Self-checking bench for the termination mode control.
// Assumes: Small resync count keeps the run short.
// Notes: Expected latencies follow from the written latency fields.
module tb_dtc_term_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic term_req;
  logic cke;
  logic refresh_cmd;
  logic term_on;
  logic term_async;
  logic [1:0] term_mode;
  logic [31:0] rd;
  logic er;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  always #20 ref_clk = ~ref_clk;
  dtc_term_ctrl #(.REFRESH_CYCLES(8), .XPDLL_CYCLES(10), .RESYNC_CYCLES(16)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .term_req(term_req), .cke(cke), .refresh_cmd(refresh_cmd), .term_on(term_on),
    .term_async(term_async), .term_mode(term_mode));
  dtc_mc_model mdl_u (.ref_clk(ref_clk), .term_req(term_req), .cke(cke), .refresh_cmd(refresh_cmd));
  task automatic stop_test();
    if (err_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // One APB transfer; only the bench timeout ends the wait for ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_mode(input logic [1:0] m, input int lim);
    int n = 0;
    while (term_mode !== m && n < lim) begin
      tick(1);
      n++;
    end
  endtask
  task automatic t_regs();
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk("lat", rd, 32'h0000_0005);
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk("status", rd, 32'h0000_0000);
    apb(1'b1, 8'h0C, 32'h0000_00FF);
    chk("unmapped", 32'(er), 32'h0000_0001);
  endtask
  // Sync latency tracks additive latency; read gap turns it off and on
  task automatic t_sync();
    for (int al = 0; al < 3; al += 2) begin
      apb(1'b1, 8'h04, 32'h0000_0005 | 32'(al << 4));
      apb(1'b1, 8'h00, 32'h0000_0001);
      mdl_u.pins(1'b1, 1'b1);
      tick(3 + al);
      chk("sync on early", 32'(term_on), 32'h0000_0000);
      tick(1);
      chk("sync on", 32'(term_on), 32'h0000_0001);
      mdl_u.read_gap(8);
      tick(3 + al);
      chk("read gap", 32'(term_on), 32'h0000_0000);
      tick(1);
      chk("restore", 32'(term_on), 32'h0000_0001);
      mdl_u.pins(1'b0, 1'b1);
      tick(8);
    end
  endtask
  // Power-down with DLL off: async response ignores additive latency
  task automatic t_async();
    mdl_u.pins(1'b0, 1'b0);
    tick(1);
    chk("mode pre", 32'(term_mode), 32'h0000_0000);
    tick(1);
    chk("mode async", 32'(term_mode), 32'h0000_0003);
    mdl_u.pins(1'b1, 1'b0);
    tick(1);
    // The flag trails the mode by a cycle: it names the timing of the current output
    chk("async flag", 32'(term_async), 32'h0000_0001);
    chk("async on early", 32'(term_on), 32'h0000_0000);
    tick(1);
    chk("async on", 32'(term_on), 32'h0000_0001);
    mdl_u.pins(1'b0, 1'b0);
    tick(2);
    chk("async off", 32'(term_on), 32'h0000_0000);
    mdl_u.pins(1'b0, 1'b1);
    // WL 7: lead WL-1 plus 10 exit cycles, after two edges of clock-enable pickup
    tick(18);
    chk("exit held", 32'(term_mode), 32'h0000_0002);
    tick(1);
    chk("exit end", 32'(term_mode), 32'h0000_0000);
  endtask
  task automatic t_nopd();
    apb(1'b1, 8'h00, 32'h0000_0005);
    mdl_u.pins(1'b0, 1'b0);
    tick(4);
    chk("dll on mode", 32'(term_mode), 32'h0000_0000);
    chk("dll on flag", 32'(term_async), 32'h0000_0000);
    mdl_u.pins(1'b0, 1'b1);
    tick(4);
  endtask
  task automatic t_refresh();
    apb(1'b1, 8'h00, 32'h0000_0001);
    mdl_u.refresh_pd();
    tick(5);
    chk("refresh entry", 32'(term_mode), 32'h0000_0001);
    wait_mode(2'b11, 10);
    chk("refresh end", 32'(term_mode), 32'h0000_0003);
    mdl_u.pins(1'b0, 1'b1);
    wait_mode(2'b00, 40);
  endtask
  task automatic t_resync();
    apb(1'b1, 8'h00, 32'h0000_0009);
    tick(1);
    chk("resync flag", 32'(term_async), 32'h0000_0001);
    mdl_u.pins(1'b1, 1'b1);
    tick(2);
    chk("resync on", 32'(term_on), 32'h0000_0001);
    tick(20);
    chk("resync done", 32'(term_async), 32'h0000_0000);
    mdl_u.pins(1'b0, 1'b1);
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    tick(2);
    t_regs();
    t_sync();
    t_async();
    t_nopd();
    t_refresh();
    t_resync();
    tick(4);
    stop_test();
  end
endmodule // tb_dtc_term_ctrl
